// *** dv/fscb_bank_tb.sv ***
// Self-checking bench for the coefficient bank and its selections.
// Assumes the host model owns the register port of the bank.
`timescale 1ns/1ps
`default_nettype none
module fscb_bank_tb;
   import fscb_pkg::*;
   localparam int HALF = 4;
   logic clk, rst, s2, s1, s0, acc, wr, rvalid, refused, idle, pseudo;
   logic bnd, aps, init_done, buf_en, route, gvalid, rsel, ref2, cext;
   logic etick, coe, mtick, pin, pin_oe, ref_low, nref, cstart, cfs;
   logic cdone, cbusy, cerr;
   logic [2:0] chs, ach, gsel;
   logic [7:0] gain;
   logic [119:0] fac;
   fscb_coeff_t wd, rd, cres, w;
   fscb_coeff_t fs [5];
   fscb_coeff_t q [$];
   int error_cnt = 0;
   int n_tests = 0;
   int seed, i, n, m;
   fscb_host_model i_fscb_host_model (.clk(clk), .reg_select_bit_two(s2),
      .reg_select_bit_one(s1), .reg_select_bit_zero(s0),
      .reg_access(acc), .reg_write(wr), .reg_wdata(wd));
   fscb_bank #(.OSC_HALF_CYC(HALF)) i_fscb_bank (.clk(clk), .rst(rst),
      .reg_select_bit_two(s2), .reg_select_bit_one(s1),
      .reg_select_bit_zero(s0), .reg_access(acc), .reg_write(wr),
      .reg_wdata(wd), .reg_rdata(rd), .reg_rvalid(rvalid),
      .reg_wr_refused(refused), .converter_idle(idle),
      .pseudo_mode(pseudo), .channel_select(chs), .conv_boundary(bnd),
      .active_channel(ach), .active_pseudo(aps), .factory_fs(fac),
      .init_done(init_done), .buffer_enable(buf_en),
      .buffer_route(route), .gain_select(gsel), .pga_gain(gain),
      .gain_code_valid(gvalid), .reference_source_select(rsel),
      .second_pair_is_ref(ref2), .clock_source_external(cext),
      .ext_clk_tick(etick), .clock_out_enable(coe),
      .mod_clk_tick(mtick), .clk_pin_out(pin), .clk_pin_oe(pin_oe),
      .ref_low(ref_low), .reference_missing_flag(nref),
      .cal_start(cstart), .cal_full_scale(cfs), .cal_done(cdone),
      .cal_result(cres), .cal_busy(cbusy), .cal_error(cerr));
   // Free running 250 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // All comparisons pass through here so the counts stay in one place.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Read results are matched against the oldest note, in order.
   always @(negedge clk) begin
      if (rvalid === 1'b1) begin
         if (q.size() == 0) check(32'h1, 32'h0);
         else check(rd, q.pop_front());
      end
   end
   task automatic rdx(input logic [2:0] sel, input fscb_coeff_t e);
      q.push_back(e);
      i_fscb_host_model.access(sel, 1'b0, '0);
   endtask
   task automatic setch(input logic p, input logic [2:0] c);
      @(posedge clk);
      pseudo <= p;
      chs <= c;
      repeat (2) @(posedge clk);
   endtask
   // Coefficient entry of the active channel, own or shared, in either input layout.
   function automatic int ix(input logic p, input logic [2:0] c);
      return p ? (c > 3 ? 4 : int'(c)) : int'(c[1:0]);
   endfunction
   // One calibration run, with the reference lost midway when bad.
   task automatic cal(input logic k, input logic bad);
      @(posedge clk);
      cres <= 24'($random(seed));
      cfs <= k;
      cstart <= 1'b1;
      @(posedge clk);
      cstart <= 1'b0;
      ref_low <= bad;
      @(negedge clk);
      check(cbusy, 1'b1);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(nref, bad);
      @(posedge clk);
      cdone <= 1'b1;
      @(posedge clk);
      cdone <= 1'b0;
      ref_low <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(cerr, bad);
   endtask
   // A hang counts as a failure and ends the run the normal way.
   initial begin
      #200000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      seed = 4464;
      {rst, idle, pseudo, bnd, buf_en, rsel, cext, etick, coe} = 9'h181;
      {ref_low, cstart, cfs, cdone} = 4'h0;
      chs = 3'h0;
      gsel = 3'h0;
      cres = '0;
      for (i = 0; i < 5; i++) fac[24*i +: 24] = 24'($random(seed));
      for (i = 0; i < 5; i++) fs[i] = fac[24*i +: 24];
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check(init_done, 1'b1);
      // Every channel in both layouts reads its own or the shared entry.
      for (i = 0; i < 16; i++) begin
         setch(i[3], i[2:0]);
         rdx(3'h7, fs[ix(i[3], i[2:0])]);
         rdx(3'h6, 24'h800000);
         check(aps, i[3]);
      end
      setch(1'b0, 3'h2);
      w = 24'($random(seed));
      i_fscb_host_model.access(3'h7, 1'b1, w);
      fs[2] = w;
      @(negedge clk);
      check(refused, 1'b0);
      rdx(3'h7, fs[2]);
      setch(1'b1, 3'h5);
      w = 24'($random(seed));
      i_fscb_host_model.access(3'h7, 1'b1, w);
      fs[4] = w;
      setch(1'b1, 3'h7);
      rdx(3'h7, fs[4]);
      rdx(3'h2, 24'h000000);
      // A write while converting is refused and leaves the entry alone.
      @(posedge clk);
      idle <= 1'b0;
      i_fscb_host_model.access(3'h7, 1'b1, ~w);
      @(negedge clk);
      check(refused, 1'b1);
      rdx(3'h7, fs[4]);
      // Channel changes wait for a conversion boundary.
      @(posedge clk);
      chs <= 3'h1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(ach, 3'h7);
      @(posedge clk);
      bnd <= 1'b1;
      @(posedge clk);
      bnd <= 1'b0;
      @(negedge clk);
      check(ach, 3'h1);
      @(posedge clk);
      idle <= 1'b1;
      cal(1'b1, 1'b0);
      fs[1] = cres;
      rdx(3'h7, fs[1]);
      cal(1'b1, 1'b1);
      rdx(3'h7, fs[1]);
      cal(1'b0, 1'b0);
      rdx(3'h6, cres);
      rdx(3'h7, fs[1]);
      // All gain codes, with buffer and reference choices alongside.
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         gsel <= i[2:0];
         buf_en <= i[0];
         rsel <= i[1];
         repeat (2) @(posedge clk);
         @(negedge clk);
         check(gain, (i < 3) ? 1 : (8 << (i - 3)));
         check(gvalid, !(i == 1 || i == 2));
         check(route, i[0]);
         check(ref2, i[1]);
      end
      // Internal divider gives one tick per two half periods.
      n = 0;
      m = 0;
      repeat (80) begin
         @(negedge clk);
         n += (mtick === 1'b1);
         m += (pin === 1'b1);
      end
      check(n, 80 / (2 * HALF));
      check(m, 40);
      check(pin_oe, 1'b1);
      @(posedge clk);
      cext <= 1'b1;
      etick <= 1'b1;
      coe <= 1'b0;
      @(posedge clk);
      etick <= 1'b0;
      @(negedge clk);
      check(mtick, 1'b1);
      check({pin_oe, pin}, 2'h0);
      @(negedge clk);
      check(mtick, 1'b0);
      repeat (4) @(posedge clk);
      check(q.size(), 0);
      end_of_test();
   end
endmodule
`default_nettype wire

// *** dv/fscb_host_model.sv ***
// Host side model of the register port: one access at a time.
// Assumes the bench calls access from one process, after reset.
`timescale 1ns/1ps
`default_nettype none
module fscb_host_model (
   input wire logic clk,
   output logic reg_select_bit_two,
   output logic reg_select_bit_one,
   output logic reg_select_bit_zero,
   output logic reg_access,
   output logic reg_write,
   output fscb_pkg::fscb_coeff_t reg_wdata
);
   import fscb_pkg::*;
   // Idle levels at time zero.
   initial begin
      reg_access = 1'b0;
      reg_write = 1'b0;
      reg_wdata = '0;
      {reg_select_bit_two, reg_select_bit_one, reg_select_bit_zero} = 3'h0;
   end
   // One access pulse; the converter idle level is left to the bench, which holds it low for the refused write.
   task automatic access(input logic [2:0] sel, input logic wr,
                         input fscb_coeff_t d);
      @(posedge clk);
      {reg_select_bit_two, reg_select_bit_one,
       reg_select_bit_zero} <= sel;
      reg_write <= wr;
      reg_wdata <= d;
      reg_access <= 1'b1;
      @(posedge clk);
      reg_access <= 1'b0;
      // Released data must not keep its last value.
      reg_wdata <= ~d;
   endtask
endmodule
`default_nettype wire

// *** src/fscb_bank.sv ***
// Top of the full-scale coefficient bank with its front-end selections.
// Assumes a serial front end that presents decoded register accesses
// and an analog side that reports conversion boundaries and calibrations.
`timescale 1ns/1ps
`default_nettype none
`include "fscb_consts.svh"

module fscb_bank #(
   parameter int DEPTH = `FSCB_BANK_DEPTH,
   parameter int OSC_HALF_CYC = `FSCB_OSC_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_select_bit_two,
   input wire logic reg_select_bit_one,
   input wire logic reg_select_bit_zero,
   input wire logic reg_access,
   input wire logic reg_write,
   input wire fscb_pkg::fscb_coeff_t reg_wdata,
   output fscb_pkg::fscb_coeff_t reg_rdata,
   output logic reg_rvalid,
   output logic reg_wr_refused,
   input wire logic converter_idle,
   input wire logic pseudo_mode,
   input wire logic [2:0] channel_select,
   input wire logic conv_boundary,
   output logic [2:0] active_channel,
   output logic active_pseudo,
   input wire logic [DEPTH*`FSCB_COEFF_W-1:0] factory_fs,
   output logic init_done,
   input wire logic buffer_enable,
   output logic buffer_route,
   input wire logic [2:0] gain_select,
   output logic [7:0] pga_gain,
   output logic gain_code_valid,
   input wire logic reference_source_select,
   output logic second_pair_is_ref,
   input wire logic clock_source_external,
   input wire logic ext_clk_tick,
   input wire logic clock_out_enable,
   output logic mod_clk_tick,
   output logic clk_pin_out,
   output logic clk_pin_oe,
   input wire logic ref_low,
   output logic reference_missing_flag,
   input wire logic cal_start,
   input wire logic cal_full_scale,
   input wire logic cal_done,
   input wire fscb_pkg::fscb_coeff_t cal_result,
   output logic cal_busy,
   output logic cal_error
);
   import fscb_pkg::*;

   localparam logic [7:0] HALF_LAST = 8'(OSC_HALF_CYC - 1);

   typedef struct packed {
      fscb_state_t st;
      logic [2:0] act_ch;
      logic act_pseudo;
      fscb_coeff_t rdata;
      logic rvalid;
      logic refused;
      logic route;
      logic [7:0] gain;
      logic gain_ok;
      logic ref2;
      logic [7:0] div_cnt;
      logic pin_lvl;
      logic mod_tick;
      logic ref_flag;
      logic err;
   } fscb_top_t;

   fscb_top_t cur;
   fscb_top_t next_cur;

   logic [2:0] sel;
   logic is_fs;
   logic is_off;
   fscb_idx_t idx;
   logic host_fs_wr;
   logic host_off_wr;
   logic fs_wr_en;
   logic off_wr_en;
   fscb_coeff_t fs_wr_data;
   fscb_coeff_t off_wr_data;
   fscb_coeff_t fs_rd;
   fscb_coeff_t off_rd;
   logic upd_fs;
   logic upd_off;
   logic err_set;
   logic cal_go;
   logic osc_tick;

   // The three select pins form the register address of the access.
   assign sel = {reg_select_bit_two, reg_select_bit_one, reg_select_bit_zero};
   assign is_fs = (sel == `FSCB_SEL_FULL_SCALE);
   assign is_off = (sel == `FSCB_SEL_OFFSET);

   // Differential maps channel to entry directly; pseudo folds the upper
   // four inputs onto the shared fifth entry.
   always_comb begin
      if (cur.act_pseudo && cur.act_ch[2]) begin
         idx = `FSCB_SHARED_IDX;
      end else begin
         idx = {1'b0, cur.act_ch[1:0]};
      end
   end

   // Host writes are only taken while the converter is quiet, so a host write
   // never changes a coefficient under a running conversion.
   assign host_fs_wr = reg_access && reg_write && is_fs && converter_idle
      && (cur.st == FSCB_ST_RUN);
   assign host_off_wr = reg_access && reg_write && is_off && converter_idle
      && (cur.st == FSCB_ST_RUN);

   // A finished calibration outranks a host write in the same cycle.
   assign fs_wr_en = upd_fs || host_fs_wr;
   assign fs_wr_data = upd_fs ? cal_result : reg_wdata;
   assign off_wr_en = upd_off || host_off_wr;
   assign off_wr_data = upd_off ? cal_result : reg_wdata;

   // Both banks share one index, keeping each channel's pair together.
   fscb_coeff_store #(
      .DEPTH(DEPTH),
      .RESET_VAL('0)
   ) u_fs_store (
      .clk(clk),
      .rst(rst),
      .load_all(cur.st == FSCB_ST_LOAD),
      .load_vec(factory_fs),
      .wr_en(fs_wr_en),
      .wr_idx(idx),
      .wr_data(fs_wr_data),
      .rd_idx(idx),
      .rd_data(fs_rd)
   );

   fscb_coeff_store #(
      .DEPTH(DEPTH),
      .RESET_VAL(`FSCB_OFFSET_RESET)
   ) u_off_store (
      .clk(clk),
      .rst(rst),
      .load_all(1'b0),
      .load_vec('0),
      .wr_en(off_wr_en),
      .wr_idx(idx),
      .wr_data(off_wr_data),
      .rd_idx(idx),
      .rd_data(off_rd)
   );

   // A calibration may start only after the factory values are in place.
   assign cal_go = cal_start && (cur.st == FSCB_ST_RUN);

   fscb_cal_unit u_cal (
      .clk(clk),
      .rst(rst),
      .cal_start(cal_go),
      .cal_full_scale(cal_full_scale),
      .cal_done(cal_done),
      .ref_low(ref_low),
      .busy(cal_busy),
      .upd_fs(upd_fs),
      .upd_off(upd_off),
      .err_set(err_set)
   );

   assign osc_tick = (cur.div_cnt == HALF_LAST);

   // Main next-state logic for access answers, selections and clocking.
   always_comb begin
      next_cur = cur;
      next_cur.rvalid = 1'b0;
      next_cur.refused = 1'b0;
      next_cur.mod_tick = 1'b0;
      if (cur.st == FSCB_ST_LOAD) begin
         next_cur.st = FSCB_ST_RUN;
      end
      // The mux only moves between conversions or while quiet.
      if (conv_boundary || converter_idle) begin
         next_cur.act_ch = channel_select;
         next_cur.act_pseudo = pseudo_mode;
      end
      if (reg_access && !reg_write) begin
         next_cur.rvalid = 1'b1;
         if (is_fs) begin
            next_cur.rdata = fs_rd;
         end else if (is_off) begin
            next_cur.rdata = off_rd;
         end else begin
            next_cur.rdata = '0;
         end
      end
      if (reg_access && reg_write && (is_fs || is_off) && !host_fs_wr
            && !host_off_wr) begin
         next_cur.refused = 1'b1;
      end
      next_cur.route = buffer_enable;
      next_cur.gain_ok = 1'b1;
      case (gain_select)
         `FSCB_GAIN_1: next_cur.gain = 8'h01;
         `FSCB_GAIN_8: next_cur.gain = 8'h08;
         `FSCB_GAIN_16: next_cur.gain = 8'h10;
         `FSCB_GAIN_32: next_cur.gain = 8'h20;
         `FSCB_GAIN_64: next_cur.gain = 8'h40;
         `FSCB_GAIN_128: next_cur.gain = 8'h80;
         default: begin
            next_cur.gain = 8'h01;
            next_cur.gain_ok = 1'b0;
         end
      endcase
      next_cur.ref2 = reference_source_select;
      // Internal oscillator stand-in: a divider from the system clock.
      if (osc_tick) begin
         next_cur.div_cnt = 8'h00;
         next_cur.pin_lvl = !cur.pin_lvl;
      end else begin
         next_cur.div_cnt = cur.div_cnt + 8'h01;
      end
      if (clock_source_external) begin
         next_cur.mod_tick = ext_clk_tick;
      end else begin
         next_cur.mod_tick = osc_tick && !cur.pin_lvl;
      end
      next_cur.ref_flag = ref_low;
      // Sticky error: set wins over the clear that a new run brings.
      if (err_set) begin
         next_cur.err = 1'b1;
      end else if (cal_go && !cal_busy) begin
         next_cur.err = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '{st: FSCB_ST_LOAD, gain: 8'h01, default: '0};
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from the state register.
   assign reg_rdata = cur.rdata;
   assign reg_rvalid = cur.rvalid;
   assign reg_wr_refused = cur.refused;
   assign active_channel = cur.act_ch;
   assign active_pseudo = cur.act_pseudo;
   assign init_done = (cur.st == FSCB_ST_RUN);
   assign buffer_route = cur.route;
   assign pga_gain = cur.gain;
   assign gain_code_valid = cur.gain_ok;
   assign second_pair_is_ref = cur.ref2;
   assign mod_clk_tick = cur.mod_tick;
   // The pin is only driven on request; otherwise it stays released.
   assign clk_pin_out = cur.pin_lvl && clock_out_enable;
   assign clk_pin_oe = clock_out_enable;
   assign reference_missing_flag = cur.ref_flag;
   assign cal_error = cur.err;

   a_fs_write_lands: assert property (
      @(posedge clk) disable iff (rst)
      (host_fs_wr && !upd_fs) ##1 (idx == $past(idx))
      |-> fs_rd == $past(reg_wdata))
      else $error("host full-scale write not stored");

   a_write_refused: assert property (
      @(posedge clk) disable iff (rst)
      (reg_access && reg_write && is_fs && !converter_idle)
      |=> reg_wr_refused)
      else $error("write while converting was not refused");

   a_factory_load: assert property (
      @(posedge clk) disable iff (rst)
      (cur.st == FSCB_ST_LOAD) ##1 (idx == 3'h0 && !fs_wr_en)
      |-> fs_rd == $past(factory_fs[`FSCB_COEFF_W-1:0]))
      else $error("factory coefficient not loaded");

   a_shared_entry: assert property (
      @(posedge clk) disable iff (rst)
      (active_pseudo && active_channel[2]) |-> idx == 3'h4)
      else $error("upper pseudo channel not on shared entry");

   a_diff_entry: assert property (
      @(posedge clk) disable iff (rst)
      !active_pseudo |-> idx == {1'b0, active_channel[1:0]})
      else $error("differential channel on wrong entry");

   a_gain_top: assert property (
      @(posedge clk) disable iff (rst)
      gain_select == 3'h7 |=> pga_gain == 8'h80 && gain_code_valid)
      else $error("gain code 7 did not give 128");

   a_mux_hold: assert property (
      @(posedge clk) disable iff (rst)
      (!conv_boundary && !converter_idle)
      |=> $stable(active_channel))
      else $error("channel changed inside a conversion");

   a_ref_flag: assert property (
      @(posedge clk) disable iff (rst)
      ref_low |=> reference_missing_flag)
      else $error("missing reference not flagged");

   a_err_sticky: assert property (
      @(posedge clk) disable iff (rst)
      (cal_error && !cal_go) |=> cal_error)
      else $error("calibration error dropped without a new run");

   a_pin_release: assert property (
      @(posedge clk) disable iff (rst)
      !clock_out_enable |-> !clk_pin_oe && !clk_pin_out)
      else $error("clock pin driven while disabled");

   c_fs_write: cover property (@(posedge clk) disable iff (rst)
      host_fs_wr);
   c_refused: cover property (@(posedge clk) disable iff (rst)
      reg_wr_refused);
   c_cal_error: cover property (@(posedge clk) disable iff (rst)
      err_set);
   c_shared_read: cover property (@(posedge clk) disable iff (rst)
      reg_access && !reg_write && is_fs && idx == 3'h4);

endmodule
`default_nettype wire

// *** src/fscb_cal_unit.sv ***
// Calibration sequencer: watches the reference during a calibration run.
// Assumes cal_done arrives as one pulse per started calibration.
`timescale 1ns/1ps
`default_nettype none

module fscb_cal_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic cal_start,
   input wire logic cal_full_scale,
   input wire logic cal_done,
   input wire logic ref_low,
   output logic busy,
   output logic upd_fs,
   output logic upd_off,
   output logic err_set
);
   import fscb_pkg::*;

   typedef struct packed {
      fscb_cal_state_t st;
      logic kind_fs;
      logic bad;
      logic upd_fs;
      logic upd_off;
      logic err;
   } fscb_cal_t;

   fscb_cal_t cur;
   fscb_cal_t next_cur;

   // A single low-reference sample anywhere in the run spoils the result.
   always_comb begin
      next_cur = cur;
      next_cur.upd_fs = 1'b0;
      next_cur.upd_off = 1'b0;
      next_cur.err = 1'b0;
      case (cur.st)
         FSCB_CAL_IDLE: begin
            if (cal_start) begin
               next_cur.st = FSCB_CAL_BUSY;
               next_cur.kind_fs = cal_full_scale;
               next_cur.bad = ref_low;
            end
         end
         FSCB_CAL_BUSY: begin
            if (cal_done) begin
               next_cur.st = FSCB_CAL_IDLE;
               if (cur.bad || ref_low) begin
                  next_cur.err = 1'b1;
               end else begin
                  next_cur.upd_fs = cur.kind_fs;
                  next_cur.upd_off = !cur.kind_fs;
               end
            end else begin
               next_cur.bad = cur.bad || ref_low;
            end
         end
         default: next_cur.st = FSCB_CAL_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '{st: FSCB_CAL_IDLE, default: '0};
      end else begin
         cur <= next_cur;
      end
   end

   assign busy = (cur.st == FSCB_CAL_BUSY);
   assign upd_fs = cur.upd_fs;
   assign upd_off = cur.upd_off;
   assign err_set = cur.err;

   a_cal_inhibit: assert property (
      @(posedge clk) disable iff (rst)
      err_set |-> !upd_fs && !upd_off)
      else $error("calibration updated despite reference loss");

   a_bad_blocks: assert property (
      @(posedge clk) disable iff (rst)
      (busy && ref_low && !cal_done) ##1 cal_done |=> err_set)
      else $error("reference loss in run did not flag an error");

endmodule
`default_nettype wire

// *** src/fscb_coeff_store.sv ***
// Flip-flop bank of calibration coefficients with one write port.
// Assumes the owner resolves write priority and gives legal indices.
`timescale 1ns/1ps
`default_nettype none
`include "fscb_consts.svh"

module fscb_coeff_store #(
   parameter int DEPTH = `FSCB_BANK_DEPTH,
   parameter logic [`FSCB_COEFF_W-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load_all,
   input wire logic [DEPTH*`FSCB_COEFF_W-1:0] load_vec,
   input wire logic wr_en,
   input wire fscb_pkg::fscb_idx_t wr_idx,
   input wire fscb_pkg::fscb_coeff_t wr_data,
   input wire fscb_pkg::fscb_idx_t rd_idx,
   output fscb_pkg::fscb_coeff_t rd_data
);
   import fscb_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][`FSCB_COEFF_W-1:0] mem;
   } fscb_store_t;

   fscb_store_t cur;
   fscb_store_t next_cur;
   logic [DEPTH-1:0][`FSCB_COEFF_W-1:0] load_word;

   // Slice the flat load vector into one word per entry.
   for (genvar i = 0; i < DEPTH; i++) begin : g_slice
      assign load_word[i] = load_vec[i*`FSCB_COEFF_W +: `FSCB_COEFF_W];
   end

   // Bulk load wins over a single write; both are rare and never overlap.
   always_comb begin
      next_cur = cur;
      if (load_all) begin
         next_cur.mem = load_word;
      end else if (wr_en && (32'(wr_idx) < DEPTH)) begin
         next_cur.mem[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur.mem <= {DEPTH{RESET_VAL}};
      end else begin
         cur <= next_cur;
      end
   end

   // Out-of-range indices read as zero rather than aliasing an entry.
   assign rd_data = (32'(rd_idx) < DEPTH) ? cur.mem[rd_idx] : '0;

endmodule
`default_nettype wire

// *** src/fscb_consts.svh ***
// Constants for the full-scale coefficient bank: selects, codes, timings.
// Assumes inclusion by bare name from the package and the design modules.
//
// Notes on behaviour
// - Register select code 111 reaches the 24-bit full-scale coefficient.
// - Each differential channel owns one of the five full-scale registers.
// - Pseudo inputs 1 to 4 own a register each and the rest share one.
// - Power-on loads each full-scale register with its factory value.
// - A full-scale calibration or a host write replaces the stored value.
// - The input is buffered when buffer enable is 1 and bypasses it at 0.
// - A three-bit gain field picks a gain of 1, 8, 16, 32, 64 or 128.
// - Reference select 1 turns pair two from outputs into reference pins.
// - Converter clock is the internal oscillator or an external clock.
// - A channel change takes effect only at a conversion boundary; the code also takes it whenever converter_idle is high.
// - A status flag is set while the external reference is missing.
// - Inputs work as four differential or eight pseudo channels.
// - Each full-scale register pairs with its channel's offset register.
// - Reference loss in a calibration blocks the update and sets error.
`ifndef FSCB_CONSTS_SVH
`define FSCB_CONSTS_SVH

`define FSCB_SEL_OFFSET 3'h6
`define FSCB_SEL_FULL_SCALE 3'h7
`define FSCB_COEFF_W 24
`define FSCB_BANK_DEPTH 5
`define FSCB_SHARED_IDX 3'h4
`define FSCB_OFFSET_RESET 24'h800000
`define FSCB_GAIN_1 3'h0
`define FSCB_GAIN_8 3'h3
`define FSCB_GAIN_16 3'h4
`define FSCB_GAIN_32 3'h5
`define FSCB_GAIN_64 3'h6
`define FSCB_GAIN_128 3'h7
`define FSCB_CLK_KHZ 250000
`define FSCB_INT_OSC_KHZ 4920
// Ticks at twice the oscillator rate so the clock pin toggles once a tick.
`define FSCB_OSC_HALF_CYC (`FSCB_CLK_KHZ / (2 * `FSCB_INT_OSC_KHZ))

`endif

// *** src/fscb_pkg.sv ***
// Types shared by the full-scale coefficient bank modules.
// Assumes the constants header is on the include path.
`default_nettype none
`include "fscb_consts.svh"

package fscb_pkg;

   typedef enum logic [0:0] {
      FSCB_ST_LOAD = 1'b0,
      FSCB_ST_RUN = 1'b1
   } fscb_state_t;

   typedef enum logic [0:0] {
      FSCB_CAL_IDLE = 1'b0,
      FSCB_CAL_BUSY = 1'b1
   } fscb_cal_state_t;

   typedef logic [`FSCB_COEFF_W-1:0] fscb_coeff_t;
   typedef logic [2:0] fscb_idx_t;

endpackage
`default_nettype wire
